// ---- hw/cmc_chopper.sv ----
// chopper configuration register and chopper phase sequencer
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`include "cmc_consts.svh"
`default_nettype none
// Summary of operation
// - high velocity forces constant off-time, msb zero
// - high velocity chopper doubles the off-time field, 12 plus 64 times field
// - fullstep above threshold, switching at 45 degrees
// - fullstep target is the 45 degree entry
// - sense bit selects high or low sensitivity
// - blank time 16, 24, 36 or 54 clocks
// - mode bit 0 runs hysteresis chopper
// - mode bit 1 adds fast decay after on
// - negative current comparator ends fast decay early
// - disable bit runs fast decay full length
// - random bit 0 keeps exact off-time
// - random bit 1 adds -12 to +3 clocks
// - off-time is 12 plus 32 times field
// - off-time field zero switches bridges off
module cmc_chopper (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  wire logic                upper_velocity_threshold_hit,
  input  wire logic                ustep_at_45,
  input  wire logic [7:0]          ustep_current,
  input  wire logic [7:0]          ustep_current_45,
  input  wire logic                coil_peak_cmp,
  input  wire logic                coil_neg_cmp,
  output cmc_pkg::cmc_phase_t      chop_phase,
  output logic                     bridge_enable,
  output logic                     sense_high,
  output logic                     fullstep_active,
  output logic [7:0]               coil_target
);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic cmc_pkg::cmc_cfg_t to_cfg(input logic [31:0] r);
    cmc_pkg::cmc_cfg_t c;
    c.hv_chopper          = r[`CMC_VHIGHCHM_POS];
    c.hv_fullstep         = r[`CMC_VHIGHFS_POS];
    c.sense_hi            = r[`CMC_VSENSE_POS];
    c.blank_sel           = r[`CMC_TBL_LSB +: 2];
    c.const_off           = r[`CMC_CHM_POS];
    c.rnd_off             = r[`CMC_RNDTF_POS];
    c.fd_cmp_dis          = r[`CMC_DISFDCC_POS];
    c.fast_decay_time_msb = r[`CMC_FD3_POS];
    c.hyst_end            = r[`CMC_HEND_LSB +: 4];
    c.hyst_start          = r[`CMC_HSTRT_LSB +: 3];
    c.off_time            = r[`CMC_TOFF_LSB +: 4];
    return c;
  endfunction : to_cfg

  // blank interval per code
  function automatic logic [5:0] blank_len(input logic [1:0] s);
    case (s)
      2'h0:    return `CMC_BLANK_0;
      2'h1:    return `CMC_BLANK_1;
      2'h2:    return `CMC_BLANK_2;
      default: return `CMC_BLANK_3;
    endcase
  endfunction : blank_len

  // slow decay length before any random offset
  function automatic logic [10:0] off_base(input logic [3:0] t, input logic dbl);
    logic [10:0] te;
    te = dbl ? {6'h00, t, 1'b0} : {7'h00, t};
    return `CMC_TOFF_BASE + (te << `CMC_TOFF_SHIFT);
  endfunction : off_base

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [31:0]         cfg_word;
  cmc_pkg::cmc_cfg_t   cfg;
  logic                dp_write;
  logic [5:0]          dp_idx;
  logic                take;
  logic [3:0]          status;

  assign cfg       = to_cfg(cfg_word);
  assign take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_idx   <= 6'h00;
    end else begin
      dp_write <= take & hwrite & (hsize == 3'h2);
      dp_idx   <= haddr[7:2];
    end
  end

  // configuration word, reserved bits held at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_word <= `CMC_CFG_RST;
    end else if (dp_write && dp_idx == `CMC_CFG_IDX) begin
      cfg_word <= hwdata & `CMC_CFG_MASK;
    end
  end

  // read data; a write still in its data phase is forwarded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      if (haddr[7:2] == `CMC_CFG_IDX) begin
        hrdata <= (dp_write && dp_idx == haddr[7:2]) ?
                  (hwdata & `CMC_CFG_MASK) : cfg_word;
      end else if (haddr[7:2] == `CMC_STATUS_IDX) begin
        hrdata <= {28'h000_0000, status};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // comparator inputs
  // ----------------------------------------------------------------
  logic [2:0] pk_sync;
  logic [2:0] ng_sync;
  logic       peak_cmp;
  logic       neg_cmp;

  // analog comparators are asynchronous; a level counts once stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pk_sync  <= 3'h0;
      ng_sync  <= 3'h0;
      peak_cmp <= 1'b0;
      neg_cmp  <= 1'b0;
    end else begin
      pk_sync <= {pk_sync[1:0], coil_peak_cmp};
      ng_sync <= {ng_sync[1:0], coil_neg_cmp};
      if (pk_sync[1] == pk_sync[2]) peak_cmp <= pk_sync[2];
      if (ng_sync[1] == ng_sync[2]) neg_cmp <= ng_sync[2];
    end
  end

  // ----------------------------------------------------------------
  // mode derivation
  // ----------------------------------------------------------------
  logic       hv_chop;
  logic       chm_eff;
  logic [3:0] tfd_eff;
  logic       drv_off;

  assign hv_chop = cfg.hv_chopper & upper_velocity_threshold_hit;
  assign chm_eff = cfg.const_off | hv_chop;
  assign tfd_eff = {cfg.fast_decay_time_msb & ~hv_chop, cfg.hyst_start};
  assign drv_off = (cfg.off_time == 4'h0);

  // ----------------------------------------------------------------
  // chopper sequencer
  // ----------------------------------------------------------------
  cmc_pkg::cmc_phase_t phase;
  cmc_pkg::cmc_phase_t next_phase;
  logic [10:0]         tmr;
  logic [5:0]          blank_cnt;
  logic                blanked;
  logic [7:0]          lfsr;
  logic [10:0]         slow_len;
  logic [10:0]         fast_len;

  assign chop_phase = phase;
  assign blanked    = (blank_cnt != 6'h00);
  assign fast_len   = {2'h0, tfd_eff, 5'h00};
  // slow length: the offset spans base-12 .. base+3
  assign slow_len   = cfg.rnd_off ?
                      off_base(cfg.off_time, hv_chop) + {7'h00, lfsr[3:0]} - `CMC_RND_DOWN :
                      off_base(cfg.off_time, hv_chop);

  // phase transitions
  always_comb begin
    next_phase = phase;
    if (drv_off) begin
      next_phase = cmc_pkg::PH_OFF;
    end else begin
      case (phase)
        cmc_pkg::PH_OFF: next_phase = cmc_pkg::PH_ON;
        cmc_pkg::PH_ON: begin
          // comparator is ignored while the switching spike settles
          if (peak_cmp && !blanked) begin
            if (chm_eff && tfd_eff != 4'h0) next_phase = cmc_pkg::PH_FAST;
            else next_phase = cmc_pkg::PH_SLOW;
          end
        end
        cmc_pkg::PH_FAST: begin
          if (tmr == 11'h000) next_phase = cmc_pkg::PH_SLOW;
          else if (neg_cmp && !blanked && !cfg.fd_cmp_dis)
            next_phase = cmc_pkg::PH_SLOW;
        end
        cmc_pkg::PH_SLOW: begin
          if (tmr == 11'h000) next_phase = cmc_pkg::PH_ON;
        end
        default: next_phase = cmc_pkg::PH_OFF;
      endcase
    end
  end

  // phase register and bridge enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase         <= cmc_pkg::PH_OFF;
      bridge_enable <= 1'b0;
    end else begin
      phase         <= next_phase;
      bridge_enable <= (next_phase != cmc_pkg::PH_OFF);
    end
  end

  // decay timer, loaded with length-1 so a phase lasts length cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr <= 11'h000;
    end else if (next_phase != phase && next_phase == cmc_pkg::PH_FAST) begin
      tmr <= fast_len - 11'h001;
    end else if (next_phase != phase && next_phase == cmc_pkg::PH_SLOW) begin
      tmr <= slow_len - 11'h001;
    end else if (tmr != 11'h000) begin
      tmr <= tmr - 11'h001;
    end
  end

  // blanking after every switching event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blank_cnt <= 6'h00;
    end else if (next_phase != phase) begin
      blank_cnt <= blank_len(cfg.blank_sel);
    end else if (blanked) begin
      blank_cnt <= blank_cnt - 6'h01;
    end
  end

  // random source, stepped once per slow phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr <= `CMC_LFSR_SEED;
    end else if (next_phase != phase && next_phase == cmc_pkg::PH_SLOW) begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // ----------------------------------------------------------------
  // fullstep and current target
  // ----------------------------------------------------------------
  // changeover only at 45 degrees, so the coil current does not jump
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fullstep_active <= 1'b0;
    end else if (ustep_at_45) begin
      fullstep_active <= cfg.hv_fullstep & upper_velocity_threshold_hit;
    end
  end

  // target current and sense range
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coil_target <= 8'h00;
      sense_high  <= 1'b0;
    end else begin
      coil_target <= fullstep_active ? ustep_current_45 : ustep_current;
      sense_high  <= cfg.sense_hi;
    end
  end

  assign status = {fullstep_active, hv_chop, phase};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [10:0] slow_cnt;
  logic [10:0] slow_exp;
  logic        slow_rnd;

  // measures each slow phase against the base length, before any random offset, computed at its entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt <= 11'h000;
      slow_exp <= 11'h000;
      slow_rnd <= 1'b0;
    end else if (next_phase == cmc_pkg::PH_SLOW && phase != cmc_pkg::PH_SLOW) begin
      slow_cnt <= 11'h001;
      slow_exp <= off_base(cfg.off_time, hv_chop);
      slow_rnd <= cfg.rnd_off;
    end else if (phase == cmc_pkg::PH_SLOW) begin
      slow_cnt <= slow_cnt + 11'h001;
    end
  end

  sequence s_slow_done;
    phase == cmc_pkg::PH_SLOW && next_phase == cmc_pkg::PH_ON;
  endsequence

  sequence s_enter_fast;
    phase == cmc_pkg::PH_ON && next_phase == cmc_pkg::PH_FAST;
  endsequence

  chk_drv_off_bridges: assert property (drv_off |=> phase == cmc_pkg::PH_OFF && !bridge_enable)
    else $error("driver not off with zero off time");

  chk_slow_exact: assert property (s_slow_done and !slow_rnd |-> slow_cnt == slow_exp)
    else $error("slow decay length wrong");

  chk_slow_random: assert property (s_slow_done and slow_rnd |->
      slow_cnt + `CMC_RND_DOWN >= slow_exp && slow_cnt <= slow_exp + `CMC_RND_UP)
    else $error("random slow decay out of range");

  chk_hv_double: assert property (phase != cmc_pkg::PH_SLOW &&
      next_phase == cmc_pkg::PH_SLOW && hv_chop && !cfg.rnd_off |=>
      tmr == `CMC_TOFF_BASE + {1'b0, $past(cfg.off_time), 6'h00} - 11'h001)
    else $error("off time not doubled");

  chk_hv_mode_force: assert property (hv_chop && phase == cmc_pkg::PH_ON &&
      next_phase != cmc_pkg::PH_ON && !drv_off |-> next_phase ==
      (cfg.hyst_start != 3'h0 ? cmc_pkg::PH_FAST : cmc_pkg::PH_SLOW))
    else $error("high velocity mode not forced");

  chk_hyst_no_fast: assert property (!chm_eff |-> next_phase != cmc_pkg::PH_FAST)
    else $error("fast decay in hysteresis mode");

  chk_fast_length: assert property (s_enter_fast ##1 (phase == cmc_pkg::PH_FAST &&
      cfg.fd_cmp_dis && !drv_off) [*1] |-> tmr == $past(fast_len) - 11'h001)
    else $error("fast decay length wrong");

  chk_fast_early_end: assert property (phase == cmc_pkg::PH_FAST && neg_cmp &&
      !blanked && !cfg.fd_cmp_dis && !drv_off |=> phase == cmc_pkg::PH_SLOW)
    else $error("fast decay not ended by comparator");

  chk_fast_full: assert property (phase == cmc_pkg::PH_FAST && cfg.fd_cmp_dis &&
      tmr != 11'h000 && !drv_off |=> phase == cmc_pkg::PH_FAST)
    else $error("fast decay cut short");

  chk_blank_load: assert property (next_phase != phase |=>
      blank_cnt == blank_len($past(cfg.blank_sel)))
    else $error("blank time wrong");

  chk_fs_at_45: assert property ($changed(fullstep_active) |-> $past(ustep_at_45))
    else $error("fullstep switched off 45 degrees");

  chk_fs_target: assert property (fullstep_active |=> coil_target == $past(ustep_current_45))
    else $error("fullstep target not 45 degree value");

  chk_sense_follow: assert property (##1 sense_high == $past(cfg.sense_hi))
    else $error("sense range not following");

endmodule : cmc_chopper
`default_nettype wire

// ---- hw/cmc_consts.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH
`define CMC_CFG_OFS       8'h6C
`define CMC_STATUS_OFS    8'h70
`define CMC_CFG_IDX       6'h1B
`define CMC_STATUS_IDX    6'h1C
`define CMC_CFG_RST       32'h0000_0000
`define CMC_CFG_MASK      32'h000F_FFFF
`define CMC_TOFF_LSB      0
`define CMC_HSTRT_LSB     4
`define CMC_HEND_LSB      7
`define CMC_FD3_POS       11
`define CMC_DISFDCC_POS   12
`define CMC_RNDTF_POS     13
`define CMC_CHM_POS       14
`define CMC_TBL_LSB       15
`define CMC_VSENSE_POS    17
`define CMC_VHIGHFS_POS   18
`define CMC_VHIGHCHM_POS  19
`define CMC_BLANK_0       6'h10
`define CMC_BLANK_1       6'h18
`define CMC_BLANK_2       6'h24
`define CMC_BLANK_3       6'h36
`define CMC_TOFF_BASE     11'h00C
`define CMC_TOFF_SHIFT    5
`define CMC_TFD_SHIFT     5
`define CMC_RND_DOWN      11'h00C
`define CMC_RND_UP        11'h003
`define CMC_LFSR_SEED     8'hA5
`endif

// ---- hw/cmc_pkg.sv ----
// types shared by the chopper configuration block
`default_nettype none
package cmc_pkg;
  typedef enum logic [1:0] {PH_OFF, PH_ON, PH_FAST, PH_SLOW} cmc_phase_t;
  typedef struct packed {
    logic       hv_chopper;
    logic       hv_fullstep;
    logic       sense_hi;
    logic [1:0] blank_sel;
    logic       const_off;
    logic       rnd_off;
    logic       fd_cmp_dis;
    logic       fast_decay_time_msb;
    logic [3:0] hyst_end;
    logic [2:0] hyst_start;
    logic [3:0] off_time;
  } cmc_cfg_t;
endpackage : cmc_pkg
`default_nettype wire

// ---- test/cmc_coil_model.sv ----
// coil current comparator model that answers the chopper phases
`default_nettype none
// ----------------------------------------
// coil model
// ----------------------------------------
module cmc_coil_model (
  input  wire cmc_pkg::cmc_phase_t phase,
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic [7:0]          on_dly,
  input  wire logic [7:0]          neg_dly,
  output logic                     peak_cmp,
  output logic                     neg_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  cmc_pkg::cmc_phase_t last;
  logic [7:0]          age;
  // current rises in on phase and falls in fast decay; slow delays answer late
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last     <= cmc_pkg::PH_OFF;
      age      <= 8'h00;
      peak_cmp <= 1'b0;
      neg_cmp  <= 1'b0;
    end else begin
      last     <= phase;
      age      <= (phase != last) ? 8'h00 : ((age == 8'hFF) ? age : age + 8'h01);
      peak_cmp <= (phase == cmc_pkg::PH_ON) && (age >= on_dly);
      neg_cmp  <= (phase == cmc_pkg::PH_FAST) && (age >= neg_dly);
    end
  end
endmodule : cmc_coil_model
`default_nettype wire

// ---- test/chopper_mode_config_upper_bits_tb_top.sv ----
// self-checking bench for the chopper configuration block
`default_nettype none
module chopper_mode_config_upper_bits_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp, vhit, at45;
  logic                peak, neg, bridge_enable, sense_high, fullstep_active;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [7:0]          ucur, ucur45, coil_target, on_dly, neg_dly;
  cmc_pkg::cmc_phase_t phase;
  cmc_pkg::cmc_cfg_t   cfg;
  int                  fails, n_compared, n, base, t, k;
  int                  blk[4] = '{16, 24, 36, 54};

  cmc_chopper i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .upper_velocity_threshold_hit(vhit), .ustep_at_45(at45), .ustep_current(ucur),
    .ustep_current_45(ucur45), .coil_peak_cmp(peak), .coil_neg_cmp(neg),
    .chop_phase(phase), .bridge_enable(bridge_enable), .sense_high(sense_high),
    .fullstep_active(fullstep_active), .coil_target(coil_target));

  cmc_coil_model i_coil (.phase(phase), .hclk(hclk), .hresetn(hresetn), .on_dly(on_dly),
    .neg_dly(neg_dly), .peak_cmp(peak), .neg_cmp(neg));

  // free-running system clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------
  // support tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic give_up();
    check("wait bound", 32'h0, 32'h1);
    results();
  endtask : give_up

  // one single word transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int w;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    w = 0;
    do begin
      @(posedge hclk);
      w++;
    end while (hreadyout !== 1'b1 && w < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      w++;
    end while (hreadyout !== 1'b1 && w < 50);
    rd = hrdata;
    if (w >= 50) give_up();
  endtask : ahb

  task automatic set_cfg();
    ahb(1'b1, 32'h0000_006C, {12'h000, cfg});
  endtask : set_cfg

  // length of the next whole occurrence of a phase, in cycles
  task automatic meas(input cmc_pkg::cmc_phase_t p);
    int w;
    // sampled on the falling edge, where the phase has settled
    w = 0;
    while (phase === p && w < 4000) begin
      @(negedge hclk);
      w++;
    end
    while (phase !== p && w < 4000) begin
      @(negedge hclk);
      w++;
    end
    n = 0;
    while (phase === p && w < 4000) begin
      @(negedge hclk);
      w++;
      n++;
    end
    if (w >= 4000) give_up();
  endtask : meas

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {fails, n_compared} = '0;
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, vhit, at45, ucur, ucur45} = '0;
    hsize   = 3'h2;
    on_dly  = 8'h01;
    neg_dly = 8'hF0;
    cfg     = '0;
    void'($urandom(32'hCEE8E228));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    check("phase after reset", {30'h0, phase}, 32'h0);
    check("bridge after reset", {31'h0, bridge_enable}, 32'h0);
    ahb(1'b0, 32'h0000_006C, 32'h0);
    check("config reset", rd, 32'h0);
    ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0040, 32'h0);
    check("unmapped read", rd, 32'h0);
    // random upper fields with the driver kept off; bit 17 set both ways
    for (int i = 0; i < 2; i++) begin
      t = ($urandom() & 32'hFFFD_FFF0) | (i << 17);
      ahb(1'b1, 32'h0000_006C, t);
      ahb(1'b0, 32'h0000_006C, 32'h0);
      check("config readback", rd, t & 32'h000F_FFFF);
      check("sense scale", {31'h0, sense_high}, i);
      check("off while toff zero", {31'h0, bridge_enable}, 32'h0);
    end
    // fixed off time, hysteresis mode: on goes straight to slow
    for (int i = 0; i < 3; i++) begin
      cfg          = '0;
      cfg.off_time = 4'($urandom_range(15, 1));
      cfg.blank_sel = 2'h1;
      set_cfg();
      meas(cmc_pkg::PH_SLOW);
      check("slow length", n, 12 + 32 * cfg.off_time);
      meas(cmc_pkg::PH_ON);
      check("phase after on", {30'h0, phase}, {30'h0, cmc_pkg::PH_SLOW});
    end
    // every blank code, against code zero
    for (int c = 0; c < 4; c++) begin
      cfg.off_time  = 4'h1;
      cfg.blank_sel = 2'(c);
      set_cfg();
      meas(cmc_pkg::PH_ON);
      meas(cmc_pkg::PH_ON);
      if (c == 0) base = n;
      check("blank step", n - base, blk[c] - 16);
    end
    // constant off time, comparator ignored, then honoured
    neg_dly               = 8'h01;
    cfg                   = '0;
    cfg.off_time          = 4'h2;
    cfg.const_off         = 1'b1;
    cfg.fd_cmp_dis        = 1'b1;
    cfg.hyst_start        = 3'($urandom_range(7, 1));
    cfg.fast_decay_time_msb = 1'($urandom());
    set_cfg();
    meas(cmc_pkg::PH_FAST);
    check("fast full", n, 32 * {cfg.fast_decay_time_msb, cfg.hyst_start});
    cfg.fd_cmp_dis          = 1'b0;
    cfg.hyst_start          = 3'h7;
    cfg.fast_decay_time_msb = 1'b1;
    set_cfg();
    meas(cmc_pkg::PH_FAST);
    check("fast cut short", n < 480, 1);
    // random off time offset
    cfg          = '0;
    cfg.rnd_off  = 1'b1;
    cfg.off_time = 4'($urandom_range(15, 1));
    set_cfg();
    repeat (6) begin
      meas(cmc_pkg::PH_SLOW);
      check("random slow", (n >= 32 * cfg.off_time) && (n <= 32 * cfg.off_time + 15), 1);
    end
    // high velocity chopper: msb forced low and off time doubled
    cfg                     = '0;
    cfg.hv_chopper          = 1'b1;
    cfg.off_time            = 4'($urandom_range(15, 1));
    cfg.fast_decay_time_msb = 1'b1;
    cfg.hyst_start          = 3'h1;
    cfg.fd_cmp_dis          = 1'b1;
    set_cfg();
    vhit <= 1'b1;
    meas(cmc_pkg::PH_SLOW);
    meas(cmc_pkg::PH_SLOW);
    check("hv slow", n, 12 + 64 * cfg.off_time);
    meas(cmc_pkg::PH_FAST);
    check("hv fast", n, 32);
    vhit <= 1'b0;
    meas(cmc_pkg::PH_SLOW);
    meas(cmc_pkg::PH_SLOW);
    check("normal slow", n, 12 + 32 * cfg.off_time);
    // fullstep engages only at the 45 degree point
    cfg             = '0;
    cfg.off_time    = 4'h1;
    cfg.hv_fullstep = 1'b1;
    set_cfg();
    ucur   <= 8'($urandom_range(127, 0));
    ucur45 <= 8'($urandom_range(255, 128));
    vhit   <= 1'b1;
    repeat (10) @(posedge hclk);
    check("no fullstep off 45", {31'h0, fullstep_active}, 32'h0);
    at45 <= 1'b1;
    k = 0;
    while (fullstep_active !== 1'b1 && k < 20) begin
      @(posedge hclk);
      k++;
    end
    at45 <= 1'b0;
    repeat (3) @(posedge hclk);
    check("fullstep on", {31'h0, fullstep_active}, 32'h1);
    check("fullstep target", {24'h0, coil_target}, {24'h0, ucur45});
    // clearing the off time stops the bridges from any phase
    cfg.off_time = 4'h0;
    set_cfg();
    repeat (3) @(posedge hclk);
    check("driver off", {31'h0, bridge_enable}, 32'h0);
    check("phase off", {30'h0, phase}, 32'h0);
    // status: fullstep still held, high velocity chopper off, phase off
    ahb(1'b0, 32'h0000_0070, 32'h0);
    check("status word", rd, 32'h0000_0008);
    check("bus response", {31'h0, hresp}, 32'h0);
    results();
  end
endmodule : chopper_mode_config_upper_bits_tb_top
`default_nettype wire
